//--- common/itl_pkg.sv
// constants, tables and carriers for the interval tick led toggler
// assumes one 250 MHz core clock and an apb master with 32-bit data
package itl_pkg;

  // clock and time figures
  localparam int          ITL_CLK_MHZ        = 250;
  localparam int          ITL_FIRST_TICK_MS  = 2;
  localparam int          ITL_DEBOUNCE_MS    = 10;
  localparam int          ITL_OSC_MHZ        = 24;

  // register byte offsets
  localparam logic [7:0]  ITL_OFF_CTRL       = 8'h00;
  localparam logic [7:0]  ITL_OFF_STATUS     = 8'h04;
  localparam logic [7:0]  ITL_OFF_MASK       = 8'h08;
  localparam logic [7:0]  ITL_OFF_COUNT      = 8'h0c;
  localparam logic [7:0]  ITL_OFF_PERIOD     = 8'h10;
  localparam logic [7:0]  ITL_OFF_OPTION     = 8'h14;

  // control fields
  localparam int          ITL_CTRL_START     = 0;
  localparam int          ITL_CTRL_SW_EN     = 1;
  localparam int          ITL_CTRL_EDGE_LSB  = 2;
  localparam logic [1:0]  ITL_EDGE_FALLING   = 2'h1;
  localparam logic [3:0]  ITL_CTRL_RESET     = 4'h4;

  // status and mask bit positions
  localparam int          ITL_ST_TICK        = 0;
  localparam int          ITL_ST_TOGGLE      = 1;
  localparam int          ITL_ST_PRESS       = 2;
  localparam int          ITL_ST_EDGE        = 3;
  localparam int          ITL_ST_W           = 4;
  localparam logic [3:0]  ITL_MASK_RESET     = 4'h0;

  // startup configuration bytes
  localparam logic [7:0]  ITL_OPT_WATCHDOG   = 8'h6e;
  localparam logic [7:0]  ITL_OPT_CLOCK      = 8'he0;

  // tick boundary
  localparam logic [7:0]  ITL_TICKS_PER_FLIP = 8'd250;

  // compare values by press count, index 0 is the first setting
  localparam logic [3:0][15:0] ITL_PERIOD_TABLE = {
    16'(8000 - 1), 16'(16000 - 1), 16'(32000 - 1), 16'(64000 - 1)};

  // debounce tick counts by press count
  localparam logic [3:0][5:0] ITL_DEBOUNCE_TABLE = {
    6'(40 + 1), 6'(20 + 1), 6'(10 + 1), 6'(5 + 1)};

  // debounce sequencer states
  typedef enum logic [2:0] {
    ITL_DB_IDLE  = 3'b001,
    ITL_DB_WAIT  = 3'b010,
    ITL_DB_CHECK = 3'b100
  } itl_db_state_e;

  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } itl_apb_req_s;

  // apb answer carrier
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } itl_apb_rsp_s;

endpackage : itl_pkg

//--- hdl/itl_top.sv
// interval tick timer with led toggle, switch debounce and apb registers
// assumes switch pin and apb inputs are synchronous to i_core_clk
module itl_top
  import itl_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  input  wire itl_apb_req_s i_apb,
  input  wire logic         i_switch_pin,
  output itl_apb_rsp_s      o_apb,
  output logic              o_led,
  output logic              o_timer_pin,
  output logic              o_timer_pin_oe,
  output logic              o_halt,
  output logic              o_irq
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [3:0]    ctrl_reg;
  logic [3:0]    ctrl_next;
  logic [3:0]    status_reg;
  logic [3:0]    status_next;
  logic [3:0]    mask_reg;
  logic [3:0]    mask_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic [15:0]   timer_reg;
  logic [15:0]   timer_next;
  logic [15:0]   active_reg;
  logic [15:0]   active_next;
  logic [15:0]   pending_reg;
  logic [15:0]   pending_next;
  logic [7:0]    tick_counter_reg;
  logic [7:0]    tick_counter_next;
  logic          led_reg;
  logic          led_next;
  logic          halt_reg;
  logic          halt_next;
  logic [1:0]    press_counter_reg;
  logic [1:0]    press_counter_next;
  logic [5:0]    db_count_reg;
  logic [5:0]    db_count_next;
  itl_db_state_e db_state_reg;
  itl_db_state_e db_state_next;
  logic          pin_prev_reg;

  logic          setup_phase;
  logic          wr_en;
  logic          mapped;
  logic          started;
  logic          channel_tick_irq;
  logic          flip;
  logic          switch_edge_irq;
  logic          press_ok;
  logic [3:0]    events;

  //////////////////////////////////////////////////////////////////////////
  // bus decode

  // setup cycle latches read data, access cycle commits writes
  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign wr_en       = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign started     = ctrl_reg[ITL_CTRL_START];

  // address map check
  always_comb begin
    unique case (i_apb.paddr)
      ITL_OFF_CTRL, ITL_OFF_STATUS, ITL_OFF_MASK,
      ITL_OFF_COUNT, ITL_OFF_PERIOD, ITL_OFF_OPTION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait state answer
  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = i_apb.psel & i_apb.penable & ~mapped;
  assign o_apb.prdata  = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // control and mask registers

  // software writable fields
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (wr_en && i_apb.paddr == ITL_OFF_CTRL) begin
      ctrl_next = i_apb.pwdata[3:0];
    end
    if (wr_en && i_apb.paddr == ITL_OFF_MASK) begin
      mask_next = i_apb.pwdata[3:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= ITL_CTRL_RESET;
      mask_reg <= ITL_MASK_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data

  // captured in the setup cycle, stable through access
  always_comb begin
    rdata_next = rdata_reg;
    if (setup_phase && !i_apb.pwrite) begin
      unique case (i_apb.paddr)
        ITL_OFF_CTRL:   rdata_next = {28'h0, ctrl_reg};
        ITL_OFF_STATUS: rdata_next = {28'h0, status_reg};
        ITL_OFF_MASK:   rdata_next = {28'h0, mask_reg};
        ITL_OFF_COUNT:  rdata_next = {14'h0, halt_reg, led_reg,
                                      6'h0, press_counter_reg,
                                      tick_counter_reg};
        ITL_OFF_PERIOD: rdata_next = {pending_reg, active_reg};
        ITL_OFF_OPTION: rdata_next = {16'h0, ITL_OPT_WATCHDOG,
                                      ITL_OPT_CLOCK};
        default:        rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interval counter and tick boundary

  // down counter expires at zero and reloads from the compare value
  assign channel_tick_irq = started && timer_reg == 16'h0;
  assign flip = channel_tick_irq &&
                tick_counter_reg == ITL_TICKS_PER_FLIP - 8'd1;

  always_comb begin
    timer_next        = timer_reg;
    tick_counter_next = tick_counter_reg;
    active_next       = active_reg;
    led_next          = led_reg;
    halt_next         = started & ~channel_tick_irq;
    if (!started) begin
      timer_next = active_reg;
    end else if (channel_tick_irq) begin
      timer_next        = active_reg;
      tick_counter_next = tick_counter_reg + 8'd1;
      if (flip) begin
        tick_counter_next = 8'h0;
        led_next          = ~led_reg;
        active_next       = pending_reg;
        timer_next        = pending_reg;
      end
    end else begin
      timer_next = timer_reg - 16'd1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      timer_reg        <= ITL_PERIOD_TABLE[0];
      active_reg       <= ITL_PERIOD_TABLE[0];
      tick_counter_reg <= 8'h0;
      led_reg          <= 1'b0;
      halt_reg         <= 1'b0;
    end else begin
      timer_reg        <= timer_next;
      active_reg       <= active_next;
      tick_counter_reg <= tick_counter_next;
      led_reg          <= led_next;
      halt_reg         <= halt_next;
    end
  end

  // led is a port bit; the timer pin function stays off
  assign o_led          = led_reg;
  assign o_halt         = halt_reg;
  assign o_timer_pin    = 1'b0;
  assign o_timer_pin_oe = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // switch edge and debounce

  // falling edge only when the select field holds the falling code
  assign switch_edge_irq = ctrl_reg[ITL_CTRL_SW_EN] &&
    ctrl_reg[ITL_CTRL_EDGE_LSB +: 2] == ITL_EDGE_FALLING &&
    pin_prev_reg && !i_switch_pin;
  assign press_ok = db_state_reg == ITL_DB_CHECK && !i_switch_pin;

  always_comb begin
    db_state_next      = db_state_reg;
    db_count_next      = db_count_reg;
    press_counter_next = press_counter_reg;
    pending_next       = pending_reg;
    unique case (db_state_reg)
      ITL_DB_IDLE: begin
        if (switch_edge_irq) begin
          db_state_next = ITL_DB_WAIT;
          db_count_next = 6'h0;
        end
      end
      ITL_DB_WAIT: begin
        if (channel_tick_irq) begin
          db_count_next = db_count_reg + 6'd1;
          if (db_count_reg + 6'd1 ==
              ITL_DEBOUNCE_TABLE[press_counter_reg]) begin
            db_state_next = ITL_DB_CHECK;
          end
        end
      end
      ITL_DB_CHECK: begin
        db_state_next = ITL_DB_IDLE;
        if (press_ok) begin
          press_counter_next = press_counter_reg + 2'd1;
          pending_next = ITL_PERIOD_TABLE[press_counter_next];
        end
      end
      default: begin
        db_state_next = ITL_DB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      db_state_reg      <= ITL_DB_IDLE;
      db_count_reg      <= 6'h0;
      press_counter_reg <= 2'h0;
      pending_reg       <= ITL_PERIOD_TABLE[0];
      pin_prev_reg      <= 1'b1;
    end else begin
      db_state_reg      <= db_state_next;
      db_count_reg      <= db_count_next;
      press_counter_reg <= press_counter_next;
      pending_reg       <= pending_next;
      pin_prev_reg      <= i_switch_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky status and interrupt

  // event set wins over a same-cycle write-one clear
  assign events = {switch_edge_irq, press_ok, flip, channel_tick_irq};

  always_comb begin
    status_next = status_reg;
    if (wr_en && i_apb.paddr == ITL_OFF_STATUS) begin
      status_next = status_reg & ~i_apb.pwdata[3:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // level interrupt from unmasked sticky bits
  assign o_irq = |(status_reg & mask_reg);

endmodule // itl_top

//--- test/itl_chk.sv
// port checker for itl_top
// assumes one clock domain, bound to itl_top from the bench
module itl_chk
  import itl_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_rstn,
  input wire itl_apb_req_s i_apb,
  input wire logic         i_switch_pin,
  input wire itl_apb_rsp_s o_apb,
  input wire logic         o_led,
  input wire logic         o_timer_pin,
  input wire logic         o_timer_pin_oe,
  input wire logic         o_halt,
  input wire logic         o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic [15:0] gap_reg, gap_next;
  logic        seen_reg, seen_next, halt_reg, fell_w, mapd_w;
  // tick detection and decode of mapped words
  assign fell_w = halt_reg && !o_halt;
  assign mapd_w = i_apb.paddr <= ITL_OFF_OPTION && i_apb.paddr[1:0] == 2'h0;
  // cycles since the last tick, saturating
  always_comb begin
    gap_next  = (gap_reg == 16'hffff) ? gap_reg : gap_reg + 16'h1;
    seen_next = seen_reg | fell_w;
    if (fell_w) gap_next = 16'h0;
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_reg  <= 16'h0;
      seen_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      gap_reg  <= gap_next;
      seen_reg <= seen_next;
      halt_reg <= o_halt;
    end
  end
  sequence s_acc;
    i_apb.psel && i_apb.penable;
  endsequence
  sequence s_rd;
    s_acc ##0 !i_apb.pwrite;
  endsequence
  AST_PIN_OFF: assert property (!o_timer_pin_oe && !o_timer_pin)
    else $error("timer pin driven");
  AST_READY: assert property (s_acc |-> o_apb.pready)
    else $error("no ready in access");
  AST_ERR_UNMAP: assert property (s_acc ##0 !mapd_w |-> o_apb.pslverr)
    else $error("no error on unmapped");
  AST_ERR_MAP: assert property (s_acc ##0 mapd_w |-> !o_apb.pslverr)
    else $error("error on mapped");
  AST_RD_UNMAP: assert property (s_rd ##0 !mapd_w |-> o_apb.prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_OPTION: assert property (s_rd ##0 i_apb.paddr == ITL_OFF_OPTION
    |-> o_apb.prdata[15:0] == {ITL_OPT_WATCHDOG, ITL_OPT_CLOCK})
    else $error("option bytes wrong");
  AST_LED_AT_TICK: assert property ($changed(o_led) |-> !o_halt)
    else $error("led moved without tick");
  AST_HALT_PULSE: assert property ($fell(o_halt) |=> o_halt[*2])
    else $error("halt low too long");
  AST_TICK_GAP: assert property (fell_w && seen_reg |-> gap_reg >= 16'd7999)
    else $error("ticks too close");
endmodule // itl_chk

//--- test/itl_sw_model.sv
// push switch model at the far side of the switch pin
// assumes an external pull-up, pin pulled low while pressed
module itl_sw_model (
  input  wire logic i_press,
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin returns to the pull-up level
  assign o_pin = !i_press;
endmodule // itl_sw_model

//--- test/tb_top.sv
// self-checking bench for itl_top
// assumes apb with pready answer and a switch model on the pin
module tb_top
  import itl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rstn, press, pin, led, tp, tp_oe, halt, irq, rerr;
  itl_apb_req_s req;
  itl_apb_rsp_s rsp;
  logic [31:0]  q;
  int           error_cnt, n_compared, n;
  itl_top dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_apb(req),
    .i_switch_pin(pin), .o_apb(rsp), .o_led(led), .o_timer_pin(tp),
    .o_timer_pin_oe(tp_oe), .o_halt(halt), .o_irq(irq));
  itl_sw_model sw_u (.i_press(press), .o_pin(pin));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    k = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= 50) error_cnt++;
    q = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
    // idle edge so a following call never reassigns req in this step
    @(posedge clk);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    #320000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rstn = 1'b0;
    press = 1'b0;
    req = '0;
    tick(12);
    rstn <= 1'b1;
    xfer(0, 8'h00, 0); chk(q, 32'h4);
    xfer(0, 8'h08, 0); chk(q, 32'h0);
    xfer(0, 8'h10, 0); chk(q, {16'(64000-1), 16'(64000-1)});
    xfer(0, 8'h14, 0); chk(q, 32'h6ee0);
    xfer(1, 8'h0c, 32'hff);
    xfer(0, 8'h0c, 0); chk(q, 32'h0);
    xfer(0, 8'h18, 0); chk({q[30:0], rerr}, 32'h1);
    $display("test registers done");
    // wrong edge code, then falling edge code
    xfer(1, 8'h00, 32'ha);
    press <= 1'b1;
    tick(4);
    press <= 1'b0;
    xfer(0, 8'h04, 0); chk(q, 32'h0);
    xfer(1, 8'h00, 32'h6);
    press <= 1'b1;
    tick(1);
    xfer(0, 8'h04, 0); chk(q, 32'h8);
    tick(1); chk(irq, 0);
    xfer(1, 8'h08, 32'h8);
    tick(1); chk(irq, 1);
    xfer(1, 8'h04, 32'h8);
    press <= 1'b0;
    tick(3); chk(irq, 0);
    xfer(0, 8'h04, 0); chk(q, 32'h0);
    $display("test switch edge done");
    // start and time the first tick
    xfer(1, 8'h00, 32'h7);
    // sample halt settled, on the falling edge
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (halt !== 1'b0 && n < 70000);
    chk(n, 32'd64000);
    xfer(0, 8'h04, 0); chk(q, 32'h1);
    xfer(0, 8'h0c, 0); chk(q, 32'h20001);
    xfer(1, 8'h08, 32'h1);
    tick(1); chk(irq, 1);
    $display("test timer done");
    end_of_test();
  end
endmodule // tb_top

bind itl_top itl_chk chk_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_apb(i_apb), .i_switch_pin(i_switch_pin), .o_apb(o_apb),
  .o_led(o_led), .o_timer_pin(o_timer_pin),
  .o_timer_pin_oe(o_timer_pin_oe), .o_halt(o_halt), .o_irq(o_irq));
